// >>> itr_pkg.sv
// Constants, field layouts and types of the interval timer
//
// Notes on behaviour
// - Eight-bit counter counts only upward, one step per selected timer tick.
// - Counting halts while run enable is 0 and proceeds while it is 1.
// - Rolling from 0xff to 0x00 sets the overflow request flag.
// - Flag stays set until software clears it; hardware never clears it.
// - No reload buffer; count continues from zero, software reloads it.
// - With interrupt enable set, overflow requests the vector at address 8.
// - Runs in normal, slow and green modes; green overflow wakes the system.
// - Divider mode ticks at Fcpu/256 for code 000 down to Fcpu/2 for 111.
// - Full sequence is 256 steps, each one selected clock period.
// - RTC source bit selects 32 kHz clock, only under the RC-with-RTC option.
// - In RTC mode the divider select is ignored; interval is half a second.
// - Mode register: run bit 7, divider bits 6..4, RTC bit 0, reset zero.
package itr_pkg;

    // ********************************************************
    // Register map
    // ********************************************************
    localparam logic [7:0] OFF_MODE = 8'h00;
    localparam logic [7:0] OFF_COUNT = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_IRQ_EN = 8'h0c;

    // ********************************************************
    // Fields and reset values
    // ********************************************************
    localparam logic [7:0] MODE_WR_MASK = 8'hf1;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] COUNT_FULL = 8'hff;
    localparam int FLAG_BIT = 0;
    localparam int IRQ_EN_BIT = 0;
    localparam logic [7:0] IRQ_VECTOR_ADDR = 8'h08;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int PRESCALE_WIDTH = 8;
    localparam int RTC_DIVIDE = 64;
    localparam int RTC_DIV_WIDTH = $clog2(RTC_DIVIDE);

    typedef struct packed {
        logic run;
        logic [2:0] divider_select;
        logic [2:0] unused;
        logic rtc_source_select;
    } itr_mode_t;

endpackage : itr_pkg

// >>> itr_prescaler.sv
// Power-of-two prescaler from the instruction-cycle clock
`timescale 1ns/10ps
`default_nettype none
module itr_prescaler #(
    parameter int WIDTH = itr_pkg::PRESCALE_WIDTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Control
    input wire logic run,
    input wire logic clr,
    input wire logic [2:0] sel,
    // Tick
    output logic tick
);

    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] term;

    // Code 0 gives the longest period, each step halves it
    function automatic logic [WIDTH-1:0] last_count(input logic [2:0] s);
        last_count = {WIDTH{1'b1}} >> s;
    endfunction : last_count

    assign term = last_count(sel);
    // Compare with >= so a shorter period picked mid-way cannot wrap
    assign tick = run & ~clr & (cnt_reg >= term);

    always_ff @(posedge clk) begin
        if (!nrst || clr || !run) begin
            cnt_reg <= '0;
        end else if (tick) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_div_spacing: assert property (
        tick |=> !tick
    ) else $error("prescaler ticked twice in a row");

    // Run, clear and code must all hold through the second cycle
    a_div_by_two: assert property (
        (tick && sel == 3'h7) ##1 (run && !clr && sel == 3'h7) ##1
            (run && !clr && sel == 3'h7) |-> tick
    ) else $error("code 7 did not divide by two");

endmodule : itr_prescaler
`default_nettype wire

// >>> itr_rtc_sync.sv
// Low-speed clock synchroniser and divide-by-64 tick
`timescale 1ns/10ps
`default_nettype none
module itr_rtc_sync #(
    parameter int DIVIDE = itr_pkg::RTC_DIVIDE
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Pin and control
    input wire logic rtc_pin,
    input wire logic hold,
    // Tick
    output logic tick
);

    localparam int W = $clog2(DIVIDE);
    localparam logic [W-1:0] LAST = W'(DIVIDE - 1);

    logic s1_reg, s2_reg, s3_reg, level_reg;
    logic rise;
    logic [W-1:0] cnt_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= rtc_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Change is accepted only once two stages agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            level_reg <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
        end
    end

    assign rise = ~level_reg & s2_reg & s3_reg;
    assign tick = rise & ~hold & (cnt_reg == LAST);

    always_ff @(posedge clk) begin
        if (!nrst || hold) begin
            cnt_reg <= '0;
        end else if (rise) begin
            cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_rtc_gap: assert property (
        tick |=> !tick [*8]
    ) else $error("rtc ticks too close together");

    a_rtc_on_rise: assert property (
        tick |=> level_reg
    ) else $error("rtc tick without a rising edge");

endmodule : itr_rtc_sync
`default_nettype wire

// >>> itr_timer.sv
// Interval timer with RTC source, APB registers and overflow interrupt
`timescale 1ns/10ps
`default_nettype none
module itr_timer (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic NRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Clock source and system state
    input wire logic RTC_CLK_32K,
    input wire logic INTERNAL_RC_WITH_RTC_OPTION,
    input wire logic GREEN_MODE,
    // Interrupt and wake
    output logic IRQ,
    output logic [7:0] IRQ_VECTOR,
    output logic WAKE
);

    // ********************************************************
    // Registers and wires
    // ********************************************************
    itr_pkg::itr_mode_t interval_timer_mode_reg;
    logic [7:0] interval_count_value_reg;
    logic [7:0] interval_count_value_next;
    logic overflow_request_flag_reg;
    logic overflow_irq_enable_reg;
    logic internal_rc_with_rtc_option_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic pready_reg;
    logic pslverr_reg;
    logic irq_reg;
    logic [7:0] irq_vector_reg;
    logic wake_reg;

    logic setup;
    logic wr_acc;
    logic wr_mode, wr_count, wr_status, wr_irq_en;
    logic run, rtc_mode;
    logic div_tick, rtc_tick, tick;
    logic overflow;
    logic irq_next;

    // ********************************************************
    // Address decode
    // ********************************************************
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == itr_pkg::OFF_MODE) || (a == itr_pkg::OFF_COUNT) ||
                    (a == itr_pkg::OFF_STATUS) ||
                    (a == itr_pkg::OFF_IRQ_EN);
    endfunction : is_mapped

    assign setup = PSEL & ~PENABLE;
    assign wr_acc = PSEL & PENABLE & pready_reg & PWRITE;
    assign wr_mode = wr_acc & (PADDR == itr_pkg::OFF_MODE);
    assign wr_count = wr_acc & (PADDR == itr_pkg::OFF_COUNT);
    assign wr_status = wr_acc & (PADDR == itr_pkg::OFF_STATUS);
    assign wr_irq_en = wr_acc & (PADDR == itr_pkg::OFF_IRQ_EN);

    always_comb begin
        prdata_next = 32'h0000_0000;
        case (PADDR)
            itr_pkg::OFF_MODE: begin
                prdata_next[7:0] = interval_timer_mode_reg;
            end
            itr_pkg::OFF_COUNT: begin
                prdata_next[7:0] = interval_count_value_reg;
            end
            itr_pkg::OFF_STATUS: begin
                prdata_next[itr_pkg::FLAG_BIT] = overflow_request_flag_reg;
            end
            itr_pkg::OFF_IRQ_EN: begin
                prdata_next[itr_pkg::IRQ_EN_BIT] = overflow_irq_enable_reg;
            end
            default: begin
                prdata_next = 32'h0000_0000;
            end
        endcase
    end

    // ********************************************************
    // APB answer
    // ********************************************************
    // Zero wait states: ready rises in the access phase
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~is_mapped(PADDR);
            if (setup && !PWRITE) begin
                prdata_reg <= prdata_next;
            end
        end
    end

    // ********************************************************
    // Mode and enable registers
    // ********************************************************
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            interval_timer_mode_reg <= itr_pkg::MODE_RESET;
        end else if (wr_mode) begin
            interval_timer_mode_reg <= PWDATA[7:0] & itr_pkg::MODE_WR_MASK;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            overflow_irq_enable_reg <= 1'b0;
        end else if (wr_irq_en) begin
            overflow_irq_enable_reg <= PWDATA[itr_pkg::IRQ_EN_BIT];
        end
    end

    // Static clock option, sampled every cycle after reset
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            internal_rc_with_rtc_option_reg <= 1'b0;
        end else begin
            internal_rc_with_rtc_option_reg <= INTERNAL_RC_WITH_RTC_OPTION;
        end
    end

    // ********************************************************
    // Timer clock selection
    // ********************************************************
    assign run = interval_timer_mode_reg.run;
    assign rtc_mode = interval_timer_mode_reg.rtc_source_select &
                      internal_rc_with_rtc_option_reg;

    // A counter write restarts the prescaler so the next step is whole
    itr_prescaler #(
        .WIDTH(itr_pkg::PRESCALE_WIDTH)
    ) u_prescaler (
        .clk(SYS_CLK),
        .nrst(NRST),
        .run(run),
        .clr(wr_count | rtc_mode),
        .sel(interval_timer_mode_reg.divider_select),
        .tick(div_tick)
    );

    itr_rtc_sync #(
        .DIVIDE(itr_pkg::RTC_DIVIDE)
    ) u_rtc_sync (
        .clk(SYS_CLK),
        .nrst(NRST),
        .rtc_pin(RTC_CLK_32K),
        .hold(~run | ~rtc_mode),
        .tick(rtc_tick)
    );

    // Divider select has no say in RTC mode
    assign tick = run & (rtc_mode ? rtc_tick : div_tick);

    // ********************************************************
    // Counter and overflow
    // ********************************************************
    assign overflow = tick & ~wr_count &
                      (interval_count_value_reg == itr_pkg::COUNT_FULL);

    always_comb begin
        interval_count_value_next = interval_count_value_reg;
        if (wr_count) begin
            interval_count_value_next = PWDATA[7:0];
        end else if (tick) begin
            // Wraps to zero with no reload
            interval_count_value_next = interval_count_value_reg + 8'h01;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            interval_count_value_reg <= itr_pkg::COUNT_RESET;
        end else begin
            interval_count_value_reg <= interval_count_value_next;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            overflow_request_flag_reg <= 1'b0;
        end else if (overflow) begin
            overflow_request_flag_reg <= 1'b1;
        end else if (wr_status && PWDATA[itr_pkg::FLAG_BIT]) begin
            overflow_request_flag_reg <= 1'b0;
        end
    end

    // ********************************************************
    // Interrupt and wake
    // ********************************************************
    assign irq_next = overflow_request_flag_reg & overflow_irq_enable_reg;

    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            irq_reg <= 1'b0;
            irq_vector_reg <= 8'h00;
        end else begin
            irq_reg <= irq_next;
            irq_vector_reg <= irq_next ? itr_pkg::IRQ_VECTOR_ADDR : 8'h00;
        end
    end

    // Counting is the same in every power mode; only green adds a wake
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= overflow & GREEN_MODE;
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign IRQ = irq_reg;
    assign IRQ_VECTOR = irq_vector_reg;
    assign WAKE = wake_reg;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    a_count_up: assert property (
        tick && !wr_count && interval_count_value_reg != 8'hff |=>
            interval_count_value_reg == $past(interval_count_value_reg) + 8'h01
    ) else $error("counter did not step by one");

    a_halt_hold: assert property (
        !run && !wr_count |=> $stable(interval_count_value_reg)
    ) else $error("counter moved while disabled");

    a_overflow_set: assert property (
        overflow |=> overflow_request_flag_reg && interval_count_value_reg == 8'h00
    ) else $error("overflow did not set flag and wrap");

    a_flag_sticky: assert property (
        overflow_request_flag_reg && !(wr_status && PWDATA[0]) |=>
            overflow_request_flag_reg
    ) else $error("flag cleared without software");

    a_irq_vector: assert property (
        overflow_request_flag_reg && overflow_irq_enable_reg |=>
            IRQ && IRQ_VECTOR == 8'h08
    ) else $error("interrupt vector not raised");

    a_green_wake: assert property (
        overflow && GREEN_MODE |=> WAKE ##1 !WAKE || overflow
    ) else $error("green overflow did not wake");

    a_rtc_ignore_div: assert property (
        rtc_mode && run |-> tick == rtc_tick
    ) else $error("divider leaked into rtc mode");

    a_count_write: assert property (
        wr_count |=> interval_count_value_reg == $past(PWDATA[7:0])
    ) else $error("counter write lost");

    a_mode_fields: assert property (
        wr_mode |=> interval_timer_mode_reg == ($past(PWDATA[7:0]) & 8'hf1)
    ) else $error("mode register fields wrong");

endmodule : itr_timer
`default_nettype wire

// >>> itr_rtc_osc.sv
// Low-speed oscillator model that drives the RTC pin of the timer
`timescale 1ns/10ps
`default_nettype none
module itr_rtc_osc #(
    parameter int HALF_NS = 210
) (
    // Oscillator output
    output logic clk_out
);
    // ********************************************************
    // Free-running crystal
    // ********************************************************
    // Scaled far above 32768 Hz so that 64 edges per step stay short;
    // the odd half period keeps it out of phase with the system clock
    initial begin
        clk_out = 1'b0;
        forever begin
            #(HALF_NS) clk_out = ~clk_out;
        end
    end
endmodule : itr_rtc_osc
`default_nettype wire

// >>> interval_timer_rtc_tb_top.sv
// Self-checking testbench of the interval timer
`timescale 1ns/10ps
`default_nettype none
module interval_timer_rtc_tb_top;
    // ********************************************************
    // Signals
    // ********************************************************
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rtc_clk;
    logic rc_opt = 1'b0;
    logic green = 1'b0;
    logic irq;
    logic [7:0] irq_vec;
    logic wake;
    logic [15:0] lfsr = 16'h9ee0;
    logic [31:0] rd;
    logic err;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int wake_cnt = 0;
    int m_count;

    always #25 clk = ~clk;

    itr_timer i_itr_timer (
        .SYS_CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RTC_CLK_32K(rtc_clk),
        .INTERNAL_RC_WITH_RTC_OPTION(rc_opt), .GREEN_MODE(green),
        .IRQ(irq), .IRQ_VECTOR(irq_vec), .WAKE(wake)
    );

    itr_rtc_osc #(.HALF_NS(210)) i_itr_rtc_osc (.clk_out(rtc_clk));

    // Hang guard well above the longest expected run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (wake === 1'b1) begin
            wake_cnt <= wake_cnt + 1;
        end
        if (cycles == 40000) begin
            fail_count++;
            final_report();
        end
    end

    // ********************************************************
    // Helpers
    // ********************************************************
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic final_report();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) begin
            chk("pready", 32'h1, 32'h0);
        end
    endtask : apb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rd_chk

    // Load, start, time the overflow, then clear as an ISR would
    task automatic run_timer(input int code, input int start, input logic g,
                             input logic rtc, input int exp, input int tol);
        int n;
        int w0;
        apb(1'b1, itr_pkg::OFF_MODE, code << 4);
        apb(1'b1, itr_pkg::OFF_COUNT, start);
        apb(1'b1, itr_pkg::OFF_STATUS, 32'h1);
        green <= g;
        w0 = wake_cnt;
        apb(1'b1, itr_pkg::OFF_MODE, 32'h80 | (code << 4) | rtc);
        n = 0;
        while (irq !== 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        n_compared++;
        if (n < exp - tol || n > exp + tol) begin
            $display("Error cycles to overflow expected %0d seen %0d", exp, n);
            fail_count++;
        end
        chk("irq vector", itr_pkg::IRQ_VECTOR_ADDR, irq_vec);
        @(posedge clk);
        chk("wake pulses", g ? 1 : 0, wake_cnt - w0);
        green <= 1'b0;
        apb(1'b1, itr_pkg::OFF_MODE, 32'h0);
        rd_chk(itr_pkg::OFF_STATUS, 32'h1, "overflow flag");
        if (exp / (256 - start) >= 16) begin
            rd_chk(itr_pkg::OFF_COUNT, 32'h0, "count after wrap");
        end
        repeat (12) @(posedge clk);
        apb(1'b1, itr_pkg::OFF_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq after clear", 32'h0, irq);
        $display("Timer run with code %0d done", code);
    endtask : run_timer

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial begin
        int st;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd_chk(itr_pkg::OFF_MODE, 32'h0, "mode reset");
        chk("mapped slverr", 32'h0, err);
        rd_chk(itr_pkg::OFF_COUNT, 32'h0, "count reset");
        rd_chk(itr_pkg::OFF_STATUS, 32'h0, "flag reset");
        rd_chk(itr_pkg::OFF_IRQ_EN, 32'h0, "enable reset");
        chk("irq reset", 32'h0, irq);
        apb(1'b1, itr_pkg::OFF_MODE, 32'hffffffff);
        rd_chk(itr_pkg::OFF_MODE, itr_pkg::MODE_WR_MASK, "mode fields");
        apb(1'b1, 8'h10, 32'h5);
        chk("write slverr", 32'h1, err);
        apb(1'b0, 8'h10, 32'h0);
        chk("read slverr", 32'h1, err);
        chk("unmapped data", 32'h0, rd);
        $display("Register test done");
        apb(1'b1, itr_pkg::OFF_MODE, 32'h70);
        lfsr = lfsr_next(lfsr);
        m_count = lfsr[7:0];
        apb(1'b1, itr_pkg::OFF_COUNT, m_count);
        repeat (300) @(posedge clk);
        rd_chk(itr_pkg::OFF_COUNT, m_count, "held count");
        $display("Halt test done");
        apb(1'b1, itr_pkg::OFF_IRQ_EN, 32'h1);
        for (int c = 0; c < 8; c++) begin
            lfsr = lfsr_next(lfsr);
            st = (c == 7) ? 0 : (32'hf0 | lfsr[3:0]);
            run_timer(c, st, c[0], 1'b0, (256 - st) * (256 >> c) + 2, 1);
        end
        // Counter loaded before start, never from the handler
        rc_opt <= 1'b1;
        // 64 pin rises of 8.4 cycles, 3 sync stages, 2 to see the interrupt
        run_timer(0, 255, 1'b1, 1'b1, 536, 4);
        rc_opt <= 1'b0;
        run_timer(7, 255, 1'b0, 1'b1, 4, 1);
        apb(1'b1, itr_pkg::OFF_IRQ_EN, 32'h0);
        apb(1'b1, itr_pkg::OFF_COUNT, 32'hff);
        apb(1'b1, itr_pkg::OFF_MODE, 32'hf0);
        repeat (10) @(posedge clk);
        chk("masked irq", 32'h0, irq);
        apb(1'b1, itr_pkg::OFF_STATUS, 32'h0);
        apb(1'b1, itr_pkg::OFF_MODE, 32'h0);
        repeat (50) @(posedge clk);
        rd_chk(itr_pkg::OFF_STATUS, 32'h1, "sticky flag");
        apb(1'b1, itr_pkg::OFF_IRQ_EN, 32'h1);
        repeat (2) @(posedge clk);
        chk("unmasked irq", 32'h1, irq);
        apb(1'b1, itr_pkg::OFF_STATUS, 32'h1);
        repeat (2) @(posedge clk);
        chk("cleared irq", 32'h0, irq);
        chk("idle vector", 32'h0, irq_vec);
        $display("Interrupt test done");
        final_report();
    end
endmodule : interval_timer_rtc_tb_top
`default_nettype wire
